// file: include/guest_trap_map.svh
// register offsets, field positions, reset values and encodings of the guest trap unit
`ifndef GUEST_TRAP_MAP_SVH
`define GUEST_TRAP_MAP_SVH

// bus address is {register number[4:0], select[2:0]}
`define GMC_ADDR 8'h66
`define CAUSE_ADDR 8'h68
`define EVT_STATUS_ADDR 8'hf8
`define EVT_CLEAR_ADDR 8'hf9
`define EVT_ENABLE_ADDR 8'hfa

// guest_mode_control fields
`define GMC_TRAP_ALL_BIT 0
`define GMC_XLATE_BIT 1
`define GMC_TIMER_BIT 2
`define GMC_CACHE_BIT 3
`define GMC_CONFIG_BIT 4
`define GMC_REDIRECT_BIT 5
`define GMC_WIDTH 6
`define GMC_RESET 6'h00

// root cause fields
`define CAUSE_CODE_LSB 2
`define CAUSE_CODE_MSB 6
`define CAUSE_KIND_LSB 8
`define CAUSE_KIND_MSB 10
`define HYPV_CAUSE_CODE 5'h1b
`define RSVD_CAUSE_CODE 5'h0a

// event bits of status, clear and enable
`define EVT_SW_FIELD 0
`define EVT_HW_FIELD 1
`define EVT_PRIV_SENSE 2
`define EVT_RSVD_REDIRECT 3
`define EVT_HYPERVISOR_CALL_INSN 4
`define EVT_COUNT 5

// guest context resources that the targeted enables gate
`define REG_TIMER_COUNT 5'h09
`define REG_TIMER_COMPARE 5'h0b
`define REG_CONFIG 5'h10
`define REG_XLATE_HI 5'h0a
`define REG_XLATE_LAST_LOW 5'h06

`endif

// file: include/guest_trap_pkg.sv
// types shared by the guest trap unit
package guest_trap_pkg;

  typedef enum logic [4:0] {
    OP_PLAIN,
    OP_READ_CP0,
    OP_WRITE_CP0,
    OP_TLB_LOCAL,
    OP_CACHE,
    OP_OTHER_PRIV,
    OP_HYPERVISOR_CALL_INSN,
    OP_MOVE_FROM_GUEST_WORD,
    OP_MOVE_TO_GUEST_WORD,
    OP_MOVE_FROM_GUEST_DWORD,
    OP_MOVE_TO_GUEST_DWORD,
    OP_GUEST_TLB_INVALIDATE,
    OP_GUEST_TLB_INVALIDATE_FLUSH,
    OP_GUEST_TLB_PROBE,
    OP_GUEST_TLB_READ,
    OP_GUEST_TLB_WRITE_INDEXED,
    OP_GUEST_TLB_WRITE_RANDOM
  } op_t;

  typedef enum logic [2:0] {
    MODE_ROOT_USER,
    MODE_ROOT_KERNEL,
    MODE_GUEST_USER,
    MODE_GUEST_KERNEL,
    MODE_DEBUG
  } mode_t;

  typedef enum logic [2:0] {
    EXC_NONE,
    EXC_SW_FIELD,
    EXC_HW_FIELD,
    EXC_PRIV_SENSE,
    EXC_RSVD_REDIRECT,
    EXC_HYPERVISOR_CALL_INSN,
    EXC_RSVD_LOCAL
  } exc_kind_t;

  typedef enum logic [2:0] {
    TLBG_NONE,
    TLBG_INV,
    TLBG_INV_FLUSH,
    TLBG_PROBE,
    TLBG_READ,
    TLBG_WRITE_IDX,
    TLBG_WRITE_RAND
  } tlb_op_t;

endpackage : guest_trap_pkg

// file: hdl/guest_trap_classify.sv
// combinational classification of one instruction against the guest trap controls
`timescale 1ns/1ps
`include "guest_trap_map.svh"

module guest_trap_classify
  import guest_trap_pkg::*;
(
  // instruction
  input wire op_t op_in,
  input wire mode_t mode_in,
  input wire logic [4:0] reg_in,
  input wire logic [2:0] sel_in,
  input wire logic field_change_in,
  input wire logic reserved_in,
  // controls
  input wire logic [`GMC_WIDTH-1:0] ctl_in,
  // decision
  output exc_kind_t kind_out,
  output logic cp0_rd_out,
  output logic cp0_wr_out,
  output logic dword_out,
  output tlb_op_t tlb_op_out
);

  function automatic logic is_xlate_reg(input logic [4:0] r);
    is_xlate_reg = (r <= `REG_XLATE_LAST_LOW) || (r == `REG_XLATE_HI);
  endfunction : is_xlate_reg

  function automatic logic is_timer_reg(input logic [4:0] r, input logic [2:0] s);
    is_timer_reg = (s == 3'h0) && ((r == `REG_TIMER_COUNT) || (r == `REG_TIMER_COMPARE));
  endfunction : is_timer_reg

  logic guest_k;
  logic root_side;
  logic gated;
  logic is_cp0;

  always_comb begin
    guest_k = (mode_in == MODE_GUEST_KERNEL);
    root_side = (mode_in == MODE_ROOT_KERNEL) || (mode_in == MODE_DEBUG);
    is_cp0 = (op_in == OP_READ_CP0) || (op_in == OP_WRITE_CP0);
    gated = 1'b0;
    if (is_cp0 && is_xlate_reg(reg_in) && ctl_in[`GMC_XLATE_BIT]) begin
      gated = 1'b1;
    end
    if (is_cp0 && is_timer_reg(reg_in, sel_in) && !ctl_in[`GMC_TIMER_BIT]) begin
      gated = 1'b1;
    end
    // config registers 0-7 are readable; only writes are gated
    if ((op_in == OP_WRITE_CP0) && (reg_in == `REG_CONFIG) && !ctl_in[`GMC_CONFIG_BIT]) begin
      gated = 1'b1;
    end
    if ((op_in == OP_TLB_LOCAL) && ctl_in[`GMC_XLATE_BIT]) begin
      gated = 1'b1;
    end
    if ((op_in == OP_CACHE) && !ctl_in[`GMC_CACHE_BIT]) begin
      gated = 1'b1;
    end
    kind_out = EXC_NONE;
    cp0_rd_out = 1'b0;
    cp0_wr_out = 1'b0;
    dword_out = 1'b0;
    tlb_op_out = TLBG_NONE;
    if (reserved_in) begin
      kind_out = ((mode_in == MODE_GUEST_KERNEL || mode_in == MODE_GUEST_USER) &&
                  ctl_in[`GMC_REDIRECT_BIT]) ? EXC_RSVD_REDIRECT : EXC_RSVD_LOCAL;
    end else begin
      unique case (op_in)
        OP_PLAIN: begin
        end
        OP_HYPERVISOR_CALL_INSN: begin
          kind_out = (guest_k || mode_in == MODE_ROOT_KERNEL) ? EXC_HYPERVISOR_CALL_INSN : EXC_RSVD_LOCAL;
        end
        OP_READ_CP0, OP_WRITE_CP0, OP_TLB_LOCAL, OP_CACHE, OP_OTHER_PRIV: begin
          if (guest_k) begin
            if (ctl_in[`GMC_TRAP_ALL_BIT] || gated) begin
              kind_out = EXC_PRIV_SENSE;
            end else if (op_in == OP_WRITE_CP0 && field_change_in) begin
              kind_out = EXC_SW_FIELD;
            end
          end
        end
        OP_MOVE_FROM_GUEST_WORD, OP_MOVE_TO_GUEST_WORD,
        OP_MOVE_FROM_GUEST_DWORD, OP_MOVE_TO_GUEST_DWORD: begin
          if (root_side) begin
            cp0_rd_out = (op_in == OP_MOVE_FROM_GUEST_WORD) ||
                         (op_in == OP_MOVE_FROM_GUEST_DWORD);
            cp0_wr_out = !cp0_rd_out;
            dword_out = (op_in == OP_MOVE_FROM_GUEST_DWORD) || (op_in == OP_MOVE_TO_GUEST_DWORD);
          end else begin
            kind_out = guest_k ? EXC_PRIV_SENSE : EXC_RSVD_LOCAL;
          end
        end
        default: begin
          if (mode_in == MODE_ROOT_KERNEL) begin
            unique case (op_in)
              OP_GUEST_TLB_INVALIDATE: tlb_op_out = TLBG_INV;
              OP_GUEST_TLB_INVALIDATE_FLUSH: tlb_op_out = TLBG_INV_FLUSH;
              OP_GUEST_TLB_PROBE: tlb_op_out = TLBG_PROBE;
              OP_GUEST_TLB_READ: tlb_op_out = TLBG_READ;
              OP_GUEST_TLB_WRITE_INDEXED: tlb_op_out = TLBG_WRITE_IDX;
              default: tlb_op_out = TLBG_WRITE_RAND;
            endcase
          end else begin
            kind_out = guest_k ? EXC_PRIV_SENSE : EXC_RSVD_LOCAL;
          end
        end
      endcase
    end
  end

endmodule : guest_trap_classify

// file: hdl/guest_privilege_trap_logic.sv
// guest privilege trap and exception control with its register port
// Operation
// - guest write to monitored field traps before it executes, field unchanged
// - fields with no hardware effect, like reduced power, still trap on change
// - hardware change of a monitored guest field raises a separate root exception
// - disabled privileged instruction in guest kernel traps to root instead
// - trap-all control makes every privileged operation in guest kernel trap
// - targeted controls gate translation, timer, cache ops and config 0-7 writes
// - redirect control sends guest reserved-instruction faults to root
// - hypervisor call traps to root from guest kernel and root kernel
// - word and dword moves between GPRs and guest CP0 from root mode
// - guest context moves also work in debug mode
// - guest TLB operations from root act on the guest TLB
// - guest mode control register sits at register 12 select 6
// - root traps report the hypervisor cause code at register 13 select 0
`timescale 1ns/1ps
`include "guest_trap_map.svh"

module guest_privilege_trap_logic
  import guest_trap_pkg::*;
#(
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // instruction at the trap stage
  input wire logic insn_valid_in,
  input wire op_t insn_op_in,
  input wire mode_t insn_mode_in,
  input wire logic [4:0] insn_reg_in,
  input wire logic [2:0] insn_sel_in,
  input wire logic insn_field_change_in,
  input wire logic insn_reserved_in,
  input wire logic [DATA_W-1:0] insn_gpr_in,
  // hardware initiated change of a monitored guest field
  input wire logic hw_field_change_in,
  // guest context register file and guest TLB
  input wire logic [DATA_W-1:0] guest_cp0_rdata_in,
  output logic guest_cp0_rd_out,
  output logic guest_cp0_wr_out,
  output logic guest_cp0_dword_out,
  output logic [7:0] guest_cp0_addr_out,
  output logic [DATA_W-1:0] guest_cp0_wdata_out,
  output tlb_op_t guest_tlb_op_out,
  output logic guest_tlb_strobe_out,
  // result to the pipeline
  output logic retire_out,
  output logic flush_out,
  output logic trap_out,
  output logic trap_to_root_out,
  output exc_kind_t trap_kind_out,
  output logic [4:0] trap_code_out,
  output logic [DATA_W-1:0] gpr_wdata_out,
  output logic gpr_we_out,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // interrupt
  output logic irq_out
);

  // local reserved faults keep their own code; every root trap, redirected ones too, gets the hypervisor code
  function automatic logic [4:0] cause_code(input exc_kind_t k);
    cause_code = (k == EXC_RSVD_LOCAL) ? `RSVD_CAUSE_CODE : `HYPV_CAUSE_CODE;
  endfunction : cause_code

  // one sticky status bit per kind of root trap
  function automatic logic [`EVT_COUNT-1:0] event_bit(input exc_kind_t k);
    event_bit = '0;
    unique case (k)
      EXC_SW_FIELD: event_bit[`EVT_SW_FIELD] = 1'b1;
      EXC_HW_FIELD: event_bit[`EVT_HW_FIELD] = 1'b1;
      EXC_PRIV_SENSE: event_bit[`EVT_PRIV_SENSE] = 1'b1;
      EXC_RSVD_REDIRECT: event_bit[`EVT_RSVD_REDIRECT] = 1'b1;
      EXC_HYPERVISOR_CALL_INSN: event_bit[`EVT_HYPERVISOR_CALL_INSN] = 1'b1;
      default: event_bit = '0;
    endcase
  endfunction : event_bit

  // control registers
  logic [`GMC_WIDTH-1:0] guest_mode_control;
  logic [`GMC_WIDTH-1:0] next_guest_mode_control;

  logic [4:0] cause_exc;
  logic [4:0] next_cause_exc;

  logic [2:0] cause_kind;
  logic [2:0] next_cause_kind;

  logic [`EVT_COUNT-1:0] evt_status;
  logic [`EVT_COUNT-1:0] next_evt_status;

  logic [`EVT_COUNT-1:0] evt_enable;
  logic [`EVT_COUNT-1:0] next_evt_enable;

  logic [31:0] next_reg_rdata;
  logic next_irq;

  // instruction result
  logic next_retire;
  logic next_flush;
  logic next_trap;
  logic next_to_root;
  exc_kind_t next_kind;
  logic [4:0] next_code;

  // guest context access
  logic next_cp0_rd;
  logic next_cp0_wr;
  logic next_dword;
  logic [7:0] next_cp0_addr;
  logic [DATA_W-1:0] next_cp0_wdata;

  // guest tlb access
  tlb_op_t next_tlb_op;
  logic next_tlb_strobe;

  // move-from return path
  logic rd_pending;
  logic next_rd_pending;
  logic rd_dword;
  logic next_rd_dword;
  logic [DATA_W-1:0] next_gpr_wdata;
  logic next_gpr_we;

  // classifier
  exc_kind_t cls_kind;
  logic cls_rd;
  logic cls_wr;
  logic cls_dword;
  tlb_op_t cls_tlb;

  guest_trap_classify u_classify (
    .op_in(insn_op_in),
    .mode_in(insn_mode_in),
    .reg_in(insn_reg_in),
    .sel_in(insn_sel_in),
    .field_change_in(insn_field_change_in),
    .reserved_in(insn_reserved_in),
    .ctl_in(guest_mode_control),
    .kind_out(cls_kind),
    .cp0_rd_out(cls_rd),
    .cp0_wr_out(cls_wr),
    .dword_out(cls_dword),
    .tlb_op_out(cls_tlb)
  );

  exc_kind_t take_kind;
  logic take_trap;

  // decide what the instruction in this cycle does
  always_comb begin
    // a hardware field change outranks the instruction, which is flushed for replay
    take_kind = EXC_NONE;
    if (hw_field_change_in) begin
      take_kind = EXC_HW_FIELD;
    end else if (insn_valid_in) begin
      take_kind = cls_kind;
    end
    take_trap = (take_kind != EXC_NONE);

    next_trap = take_trap;
    next_kind = take_kind;
    next_to_root = take_trap && (take_kind != EXC_RSVD_LOCAL);
    next_code = cause_code(take_kind);

    // a trapping instruction never retires and all younger ones are killed
    next_retire = insn_valid_in && !take_trap;
    next_flush = take_trap;

    // side effects are issued only for an instruction that retires
    next_cp0_rd = next_retire && cls_rd;
    next_cp0_wr = next_retire && cls_wr;
    next_dword = next_retire && cls_dword;
    next_cp0_addr = {insn_reg_in, insn_sel_in};
    next_cp0_wdata = cls_dword ? insn_gpr_in : DATA_W'($signed(insn_gpr_in[31:0]));
    next_tlb_strobe = next_retire && (cls_tlb != TLBG_NONE);
    next_tlb_op = next_tlb_strobe ? cls_tlb : TLBG_NONE;
    next_rd_pending = next_cp0_rd;
    next_rd_dword = cls_dword;

    // guest register data returns the cycle after the read strobe
    next_gpr_we = rd_pending;
    next_gpr_wdata = rd_dword ? guest_cp0_rdata_in :
                     DATA_W'($signed(guest_cp0_rdata_in[31:0]));
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      retire_out <= 1'b0;
      flush_out <= 1'b0;
      trap_out <= 1'b0;
      trap_to_root_out <= 1'b0;
      trap_kind_out <= EXC_NONE;
      trap_code_out <= 5'h00;

      guest_cp0_rd_out <= 1'b0;
      guest_cp0_wr_out <= 1'b0;
      guest_cp0_dword_out <= 1'b0;
      guest_cp0_addr_out <= 8'h00;
      guest_cp0_wdata_out <= '0;
      guest_tlb_op_out <= TLBG_NONE;
      guest_tlb_strobe_out <= 1'b0;

      rd_pending <= 1'b0;
      rd_dword <= 1'b0;
      gpr_we_out <= 1'b0;
      gpr_wdata_out <= '0;
    end else begin
      retire_out <= next_retire;
      flush_out <= next_flush;
      trap_out <= next_trap;
      trap_to_root_out <= next_to_root;
      trap_kind_out <= next_kind;
      trap_code_out <= next_code;

      guest_cp0_rd_out <= next_cp0_rd;
      guest_cp0_wr_out <= next_cp0_wr;
      guest_cp0_dword_out <= next_dword;
      guest_cp0_addr_out <= next_cp0_addr;
      guest_cp0_wdata_out <= next_cp0_wdata;
      guest_tlb_op_out <= next_tlb_op;
      guest_tlb_strobe_out <= next_tlb_strobe;

      rd_pending <= next_rd_pending;
      rd_dword <= next_rd_dword;
      gpr_we_out <= next_gpr_we;
      gpr_wdata_out <= next_gpr_wdata;
    end
  end

  // register writes, cause capture and sticky events
  always_comb begin
    next_guest_mode_control = guest_mode_control;
    next_evt_enable = evt_enable;
    next_cause_exc = cause_exc;
    next_cause_kind = cause_kind;
    next_evt_status = evt_status;

    if (reg_wr_in && reg_addr_in == `GMC_ADDR) begin
      next_guest_mode_control = reg_wdata_in[`GMC_WIDTH-1:0];
    end

    if (reg_wr_in && reg_addr_in == `EVT_ENABLE_ADDR) begin
      next_evt_enable = reg_wdata_in[`EVT_COUNT-1:0];
    end

    if (reg_wr_in && reg_addr_in == `EVT_CLEAR_ADDR) begin
      next_evt_status = evt_status & ~reg_wdata_in[`EVT_COUNT-1:0];
    end

    // setting after clearing lets an event in the clear cycle survive
    if (next_to_root) begin
      next_cause_exc = next_code;
      next_cause_kind = next_kind;
      next_evt_status = next_evt_status | event_bit(next_kind);
    end

    // the level follows what status and enable will hold after this edge
    next_irq = |(next_evt_status & next_evt_enable);

    // unmapped addresses and the write-only clear register read as zero
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `GMC_ADDR: next_reg_rdata[`GMC_WIDTH-1:0] = guest_mode_control;
        `CAUSE_ADDR: begin
          next_reg_rdata[`CAUSE_CODE_MSB:`CAUSE_CODE_LSB] = cause_exc;
          next_reg_rdata[`CAUSE_KIND_MSB:`CAUSE_KIND_LSB] = cause_kind;
        end
        `EVT_STATUS_ADDR: next_reg_rdata[`EVT_COUNT-1:0] = evt_status;
        `EVT_ENABLE_ADDR: next_reg_rdata[`EVT_COUNT-1:0] = evt_enable;
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      guest_mode_control <= `GMC_RESET;
      evt_enable <= '0;
      evt_status <= '0;
      cause_exc <= 5'h00;
      cause_kind <= 3'h0;

      reg_rdata_out <= 32'h0000_0000;
      irq_out <= 1'b0;
    end else begin
      guest_mode_control <= next_guest_mode_control;
      evt_enable <= next_evt_enable;
      evt_status <= next_evt_status;
      cause_exc <= next_cause_exc;
      cause_kind <= next_cause_kind;

      reg_rdata_out <= next_reg_rdata;
      irq_out <= next_irq;
    end
  end

endmodule : guest_privilege_trap_logic

// file: bench/guest_trap_asserts.sv
// port-level concurrent checks of the guest privilege trap unit
`timescale 1ns/1ps
`include "guest_trap_map.svh"

module guest_trap_asserts
  import guest_trap_pkg::*;
#(
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // instruction
  input wire logic insn_valid_in,
  input wire op_t insn_op_in,
  input wire mode_t insn_mode_in,
  input wire logic [4:0] insn_reg_in,
  input wire logic [2:0] insn_sel_in,
  input wire logic insn_reserved_in,
  input wire logic [DATA_W-1:0] insn_gpr_in,
  input wire logic hw_field_change_in,
  // guest context
  input wire logic [DATA_W-1:0] guest_cp0_rdata_in,
  input wire logic guest_cp0_rd_out,
  input wire logic guest_cp0_wr_out,
  input wire logic guest_cp0_dword_out,
  input wire logic [7:0] guest_cp0_addr_out,
  input wire logic [DATA_W-1:0] guest_cp0_wdata_out,
  input wire tlb_op_t guest_tlb_op_out,
  input wire logic guest_tlb_strobe_out,
  // result
  input wire logic retire_out,
  input wire logic flush_out,
  input wire logic trap_out,
  input wire logic trap_to_root_out,
  input wire exc_kind_t trap_kind_out,
  input wire logic [4:0] trap_code_out,
  input wire logic [DATA_W-1:0] gpr_wdata_out,
  input wire logic gpr_we_out
);
  // a hardware field change overrides the stage instruction, so it is excluded here
  logic clean;
  assign clean = insn_valid_in && !insn_reserved_in && !hw_field_change_in;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence move_from_req_s;
    clean && insn_op_in == OP_MOVE_FROM_GUEST_DWORD && insn_mode_in == MODE_ROOT_KERNEL;
  endsequence
  sequence move_from_done_s;
    guest_cp0_rd_out && retire_out ##1 gpr_we_out && gpr_wdata_out == $past(guest_cp0_rdata_in);
  endsequence

  plain_retire_a: assert property (clean && insn_op_in == OP_PLAIN |=> retire_out && !trap_out)
    else $error("plain instruction did not retire");
  hw_field_a: assert property (hw_field_change_in |=> trap_out && trap_to_root_out && trap_kind_out == EXC_HW_FIELD)
    else $error("hardware field change not trapped");
  trap_precise_a: assert property (trap_out |-> flush_out && !retire_out && !guest_cp0_wr_out && !guest_tlb_strobe_out)
    else $error("trap left side effects");
  guest_move_a: assert property (clean && insn_mode_in == MODE_GUEST_KERNEL && insn_op_in inside {[OP_MOVE_FROM_GUEST_WORD:OP_MOVE_TO_GUEST_DWORD]} |=> trap_out && trap_kind_out == EXC_PRIV_SENSE)
    else $error("guest move not trapped");
  hypervisor_call_insn_trap_a: assert property (clean && insn_op_in == OP_HYPERVISOR_CALL_INSN && insn_mode_in inside {MODE_GUEST_KERNEL, MODE_ROOT_KERNEL} |=> trap_out && trap_to_root_out && trap_kind_out == EXC_HYPERVISOR_CALL_INSN && trap_code_out == `HYPV_CAUSE_CODE)
    else $error("hypervisor call not trapped to root");
  move_to_a: assert property (clean && insn_op_in == OP_MOVE_TO_GUEST_DWORD && insn_mode_in inside {MODE_ROOT_KERNEL, MODE_DEBUG} |=> guest_cp0_wr_out && guest_cp0_dword_out && guest_cp0_addr_out == {$past(insn_reg_in), $past(insn_sel_in)} && guest_cp0_wdata_out == $past(insn_gpr_in))
    else $error("guest move-to wrong");
  move_from_a: assert property (move_from_req_s |=> move_from_done_s)
    else $error("guest move-from wrong");
  tlb_read_a: assert property (clean && insn_op_in == OP_GUEST_TLB_READ && insn_mode_in == MODE_ROOT_KERNEL |=> guest_tlb_strobe_out && guest_tlb_op_out == TLBG_READ && !trap_out)
    else $error("guest tlb read wrong");
  rsvd_local_a: assert property (insn_valid_in && insn_reserved_in && !hw_field_change_in && insn_mode_in == MODE_ROOT_KERNEL |=> trap_out && !trap_to_root_out && trap_kind_out == EXC_RSVD_LOCAL && trap_code_out == `RSVD_CAUSE_CODE)
    else $error("root reserved instruction wrong");
endmodule : guest_trap_asserts

bind guest_privilege_trap_logic guest_trap_asserts #(.DATA_W(DATA_W)) u_asserts (
  .clk_sys_in, .rst_n_in, .insn_valid_in, .insn_op_in, .insn_mode_in, .insn_reg_in,
  .insn_sel_in, .insn_reserved_in, .insn_gpr_in, .hw_field_change_in, .guest_cp0_rdata_in,
  .guest_cp0_rd_out, .guest_cp0_wr_out, .guest_cp0_dword_out, .guest_cp0_addr_out,
  .guest_cp0_wdata_out, .guest_tlb_op_out, .guest_tlb_strobe_out, .retire_out, .flush_out,
  .trap_out, .trap_to_root_out, .trap_kind_out, .trap_code_out, .gpr_wdata_out, .gpr_we_out
);

// file: bench/testbench.sv
// self-checking bench of the guest privilege trap unit
`timescale 1ns/1ps
`include "guest_trap_map.svh"

module testbench
  import guest_trap_pkg::*;
;
  logic clk_sys_in, rst_n_in, insn_valid_in, insn_field_change_in, insn_reserved_in;
  op_t insn_op_in;
  mode_t insn_mode_in;
  logic [4:0] insn_reg_in;
  // select is held at zero so the timer gating sees its registers
  logic [2:0] insn_sel_in = 3'h0;
  logic [63:0] insn_gpr_in, guest_cp0_rdata_in, guest_cp0_wdata_out, gpr_wdata_out;
  logic hw_field_change_in, reg_wr_in, reg_rd_in, irq_out, gpr_we_out;
  logic guest_cp0_rd_out, guest_cp0_wr_out, guest_cp0_dword_out, guest_tlb_strobe_out;
  logic retire_out, flush_out, trap_out, trap_to_root_out;
  logic [7:0] guest_cp0_addr_out, reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [4:0] trap_code_out;
  tlb_op_t guest_tlb_op_out;
  exc_kind_t trap_kind_out;
  int num_errors = 0;
  int compares = 0;

  guest_privilege_trap_logic #(.DATA_W(64)) dut (
    .clk_sys_in, .rst_n_in, .insn_valid_in, .insn_op_in, .insn_mode_in, .insn_reg_in,
    .insn_sel_in, .insn_field_change_in, .insn_reserved_in, .insn_gpr_in,
    .hw_field_change_in, .guest_cp0_rdata_in, .guest_cp0_rd_out, .guest_cp0_wr_out,
    .guest_cp0_dword_out, .guest_cp0_addr_out, .guest_cp0_wdata_out, .guest_tlb_op_out,
    .guest_tlb_strobe_out, .retire_out, .flush_out, .trap_out, .trap_to_root_out,
    .trap_kind_out, .trap_code_out, .gpr_wdata_out, .gpr_we_out, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out
  );

  always #2.5 clk_sys_in = ~clk_sys_in;

  task automatic chk(input string n, input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("reg_rdata_out", reg_rdata_out, e);
  endtask : rd

  // one instruction; returns just after the answer edge
  task automatic ins(input op_t o, input mode_t m, input logic [4:0] r, input logic f,
                     input logic v);
    @(posedge clk_sys_in);
    insn_valid_in <= 1'b1;
    insn_op_in <= o;
    insn_mode_in <= m;
    insn_reg_in <= r;
    insn_field_change_in <= f;
    insn_reserved_in <= v;
    @(posedge clk_sys_in);
    insn_valid_in <= 1'b0;
    insn_field_change_in <= 1'b0;
    insn_reserved_in <= 1'b0;
    #1;
  endtask : ins

  task automatic tr(input exc_kind_t k, input logic root);
    chk("trap_out", trap_out, k != EXC_NONE);
    chk("retire_out", retire_out, k == EXC_NONE);
    if (k != EXC_NONE) begin
      chk("trap_kind_out", trap_kind_out, k);
      chk("trap_to_root_out", trap_to_root_out, root);
      chk("flush_out", flush_out, 1'b1);
      chk("guest_cp0_wr_out", guest_cp0_wr_out, 1'b0);
      if (k == EXC_RSVD_LOCAL) begin
        chk("trap_code_out", trap_code_out, `RSVD_CAUSE_CODE);
      end else begin
        chk("trap_code_out", trap_code_out, `HYPV_CAUSE_CODE);
      end
    end
  endtask : tr

  task automatic trap_all_irq();
    rd(`GMC_ADDR, 32'(`GMC_RESET));
    rd(8'h00, 32'h0);
    wr(`EVT_STATUS_ADDR, 32'h1f);
    wr(`GMC_ADDR, 32'h1d);
    rd(`GMC_ADDR, 32'h1d);
    ins(OP_READ_CP0, MODE_GUEST_KERNEL, `REG_TIMER_COUNT, 1'b0, 1'b0);
    tr(EXC_PRIV_SENSE, 1'b1);
    @(posedge clk_sys_in);
    #1;
    chk("irq_out", irq_out, 1'b0);
    rd(`EVT_STATUS_ADDR, 32'h4);
    rd(`CAUSE_ADDR, (32'(EXC_PRIV_SENSE) << `CAUSE_KIND_LSB) |
       (32'(`HYPV_CAUSE_CODE) << `CAUSE_CODE_LSB));
    wr(`EVT_ENABLE_ADDR, 32'h4);
    @(posedge clk_sys_in);
    #1;
    chk("irq_out", irq_out, 1'b1);
    wr(`EVT_CLEAR_ADDR, 32'h4);
    @(posedge clk_sys_in);
    #1;
    chk("irq_out", irq_out, 1'b0);
  endtask : trap_all_irq

  task automatic field_change();
    wr(`GMC_ADDR, 32'h0);
    ins(OP_WRITE_CP0, MODE_GUEST_KERNEL, 5'h0c, 1'b1, 1'b0);
    tr(EXC_SW_FIELD, 1'b1);
    ins(OP_WRITE_CP0, MODE_GUEST_KERNEL, 5'h0c, 1'b0, 1'b0);
    tr(EXC_NONE, 1'b0);
    ins(OP_PLAIN, MODE_GUEST_KERNEL, 5'h00, 1'b0, 1'b0);
    tr(EXC_NONE, 1'b0);
    @(posedge clk_sys_in);
    hw_field_change_in <= 1'b1;
    @(posedge clk_sys_in);
    hw_field_change_in <= 1'b0;
    #1;
    tr(EXC_HW_FIELD, 1'b1);
  endtask : field_change

  task automatic targeted();
    op_t o[4] = '{OP_READ_CP0, OP_CACHE, OP_WRITE_CP0, OP_READ_CP0};
    logic [4:0] r[4] = '{`REG_TIMER_COUNT, 5'h00, `REG_CONFIG, `REG_XLATE_HI};
    int b[4] = '{`GMC_TIMER_BIT, `GMC_CACHE_BIT, `GMC_CONFIG_BIT, `GMC_XLATE_BIT};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 2; j++) begin
        wr(`GMC_ADDR, 32'(j) << b[i]);
        ins(o[i], MODE_GUEST_KERNEL, r[i], 1'b0, 1'b0);
        tr(((j == 1) == (b[i] == `GMC_XLATE_BIT)) ? EXC_PRIV_SENSE : EXC_NONE, 1'b1);
      end
    end
  endtask : targeted

  task automatic redirect_hypervisor_call_insn();
    wr(`GMC_ADDR, 32'h1 << `GMC_REDIRECT_BIT);
    ins(OP_PLAIN, MODE_GUEST_KERNEL, 5'h00, 1'b0, 1'b1);
    tr(EXC_RSVD_REDIRECT, 1'b1);
    ins(OP_PLAIN, MODE_ROOT_KERNEL, 5'h00, 1'b0, 1'b1);
    tr(EXC_RSVD_LOCAL, 1'b0);
    ins(OP_HYPERVISOR_CALL_INSN, MODE_GUEST_KERNEL, 5'h00, 1'b0, 1'b0);
    tr(EXC_HYPERVISOR_CALL_INSN, 1'b1);
    ins(OP_HYPERVISOR_CALL_INSN, MODE_ROOT_KERNEL, 5'h00, 1'b0, 1'b0);
    tr(EXC_HYPERVISOR_CALL_INSN, 1'b1);
  endtask : redirect_hypervisor_call_insn

  task automatic moves_tlb();
    @(posedge clk_sys_in);
    guest_cp0_rdata_in <= 64'h8000000000000001;
    insn_gpr_in <= 64'h0123456789abcdef;
    ins(OP_MOVE_TO_GUEST_DWORD, MODE_ROOT_KERNEL, 5'h0c, 1'b0, 1'b0);
    chk("guest_cp0_wr_out", guest_cp0_wr_out, 1'b1);
    chk("guest_cp0_addr_out", guest_cp0_addr_out, 8'h60);
    chk("guest_cp0_wdata_out", guest_cp0_wdata_out, 64'h0123456789abcdef);
    ins(OP_MOVE_TO_GUEST_WORD, MODE_DEBUG, 5'h0c, 1'b0, 1'b0);
    chk("guest_cp0_dword_out", guest_cp0_dword_out, 1'b0);
    chk("guest_cp0_wdata_out", guest_cp0_wdata_out, 64'hffffffff89abcdef);
    ins(OP_MOVE_FROM_GUEST_DWORD, MODE_ROOT_KERNEL, 5'h09, 1'b0, 1'b0);
    chk("guest_cp0_rd_out", guest_cp0_rd_out, 1'b1);
    @(posedge clk_sys_in);
    #1;
    chk("gpr_we_out", gpr_we_out, 1'b1);
    chk("gpr_wdata_out", gpr_wdata_out, 64'h8000000000000001);
    ins(OP_MOVE_FROM_GUEST_WORD, MODE_GUEST_KERNEL, 5'h0c, 1'b0, 1'b0);
    tr(EXC_PRIV_SENSE, 1'b1);
    for (int k = 0; k < 6; k++) begin
      ins(op_t'(OP_GUEST_TLB_INVALIDATE + k), MODE_ROOT_KERNEL, 5'h00, 1'b0, 1'b0);
      chk("guest_tlb_strobe_out", guest_tlb_strobe_out, 1'b1);
      chk("guest_tlb_op_out", guest_tlb_op_out, tlb_op_t'(TLBG_INV + k));
    end
  endtask : moves_tlb

  initial begin
    clk_sys_in = 1'b0;
    rst_n_in = 1'b0;
    insn_valid_in = 1'b0;
    insn_op_in = OP_PLAIN;
    insn_mode_in = MODE_ROOT_KERNEL;
    insn_reg_in = 5'h00;
    insn_field_change_in = 1'b0;
    insn_reserved_in = 1'b0;
    insn_gpr_in = 64'h0;
    hw_field_change_in = 1'b0;
    guest_cp0_rdata_in = 64'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    trap_all_irq();
    field_change();
    targeted();
    redirect_hypervisor_call_insn();
    moves_tlb();
    print_verdict();
  end

  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    num_errors++;
    print_verdict();
  end
endmodule : testbench
